/* core/hcfg_loader.sv */
// hub power-up configuration source selection and strap decode
//
// Function
// - after reset probe flash first; valid signature selects flash execution.
// - flash present but invalid signature falls back to built-in defaults.
// - only without flash, check whether management serial port is enabled.
// - both select pins pulled up gives SMBus slave; both floating gives I2C unless IO mode 6.
// - SMBus slave waits forever for host data; no enumeration until told.
// - pin b pulled down with pin a floating enables UART bridge.
// - UART bridge supports two-wire signalling; full modem signalling only in IO mode 6.
// - pull-down enables UART in IO modes 1-5; mode 6 needs no pull-down.
// - no valid flash and no SMBus configuration applies internal defaults.
// - default configuration loads identifiers and settings from internal ROM.
// - attribute straps used only when configuration is not from flash.
// - each attribute strap resolves to exactly one of six levels.
// - charge strap level n enables charging on ports 1..n-1; 6 reserved.
// - non-removable strap level n marks ports 1..n-1; 6 reserved.
// - port with both data lines high at configuration is disabled.
// - disabled ports reduce reported count and hold power drive low.
// - without disable straps all four downstream ports are enabled.
`timescale 1ns/10ps
`default_nettype none
`include "hcfg_map.svh"
module hcfg_loader #(
	parameter int NPORTS = `HCFG_NPORTS,
	parameter int PROBE_CYC = `HCFG_PROBE_CYC
) (
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic flash_present_i,
	input wire logic flash_sig_valid_i,
	input wire logic smbus_enable_i,
	input wire logic [1:0] serial_select_pin_a_i,
	input wire logic [1:0] serial_select_pin_b_i,
	input wire logic [2:0] io_mode_i,
	input wire logic modem_signals_i,
	input wire logic [`HCFG_LVL_W-1:0] charge_attr_strap_i,
	input wire logic [`HCFG_LVL_W-1:0] nonrem_attr_strap_i,
	input wire logic [NPORTS-1:0] port_dp_high_i,
	input wire logic [NPORTS-1:0] port_dm_high_i,
	input wire logic [NPORTS-1:0] port_power_req_i,
	input wire logic smbus_cfg_done_i,
	output logic [1:0] cfg_source_o,
	output logic [1:0] serial_mode_o,
	output logic uart_enable_o,
	output logic uart_modem_o,
	output logic rom_defaults_o,
	output logic flash_exec_o,
	output logic [NPORTS-1:0] charge_enable_o,
	output logic [NPORTS-1:0] nonrem_o,
	output logic [NPORTS-1:0] port_enable_o,
	output logic [2:0] port_count_o,
	output logic [NPORTS-1:0] port_power_drive_o,
	output logic enum_enable_o,
	output logic cfg_done_o
);
	typedef enum logic [4:0] {
		ST_PROBE = 5'b00001,
		ST_SEL = 5'b00010,
		ST_SMB = 5'b00100,
		ST_LOAD = 5'b01000,
		ST_RUN = 5'b10000
	} hcfg_state_t;

	hcfg_state_t state_q;
	logic [15:0] wait_q;
	logic [`HCFG_LVL_W-1:0] chg_lvl_q;
	logic [`HCFG_LVL_W-1:0] nrem_lvl_q;
	logic [NPORTS-1:0] chg_mask;
	logic [NPORTS-1:0] nrem_mask;
	logic [2:0] count_d;

	hcfg_lvl_decode #(.NPORTS(NPORTS)) u_chg (
		.level_i(chg_lvl_q),
		.dflt_i(`HCFG_LVL_CHG_DEF),
		.mask_o(chg_mask)
	);
	hcfg_lvl_decode #(.NPORTS(NPORTS)) u_nrem (
		.level_i(nrem_lvl_q),
		.dflt_i(`HCFG_LVL_NREM_DEF),
		.mask_o(nrem_mask)
	);

	// sequence: probe flash, then serial port, then defaults
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			state_q <= ST_PROBE;
			wait_q <= '0;
		end else begin
			case (state_q)
				ST_PROBE: begin
					if (wait_q == 16'(PROBE_CYC - 1)) begin
						state_q <= ST_SEL;
					end else begin
						wait_q <= wait_q + 16'h0001;
					end
				end
				ST_SEL: begin
					if (flash_present_i && flash_sig_valid_i) begin
						state_q <= ST_RUN;
					end else if (!flash_present_i && smbus_enable_i &&
						serial_select_pin_a_i == `HCFG_PIN_PU &&
						serial_select_pin_b_i == `HCFG_PIN_PU) begin
						state_q <= ST_SMB;
					end else begin
						state_q <= ST_LOAD;
					end
				end
				ST_SMB: begin
					// no timeout while waiting on the host
					if (smbus_cfg_done_i) begin
						state_q <= ST_RUN;
					end
				end
				ST_LOAD: state_q <= ST_RUN;
				ST_RUN: state_q <= ST_RUN;
				default: state_q <= ST_PROBE;
			endcase
		end
	end

	// configuration source and rom-default load
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			cfg_source_o <= hcfg_pkg::HCFG_SRC_NONE;
			rom_defaults_o <= 1'b0;
			flash_exec_o <= 1'b0;
		end else if (state_q == ST_SEL) begin
			if (flash_present_i && flash_sig_valid_i) begin
				cfg_source_o <= hcfg_pkg::HCFG_SRC_FLASH;
				flash_exec_o <= 1'b1;
			end else if (!flash_present_i && smbus_enable_i &&
				serial_select_pin_a_i == `HCFG_PIN_PU &&
				serial_select_pin_b_i == `HCFG_PIN_PU) begin
				cfg_source_o <= hcfg_pkg::HCFG_SRC_SMBUS;
			end else begin
				cfg_source_o <= hcfg_pkg::HCFG_SRC_ROM;
				rom_defaults_o <= 1'b1;
			end
		end
	end

	// serial select decode, captured once
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			serial_mode_o <= hcfg_pkg::HCFG_SER_NONE;
			uart_enable_o <= 1'b0;
			uart_modem_o <= 1'b0;
		end else if (state_q == ST_SEL) begin
			if (serial_select_pin_a_i == `HCFG_PIN_PU &&
				serial_select_pin_b_i == `HCFG_PIN_PU) begin
				serial_mode_o <= hcfg_pkg::HCFG_SER_SMB;
			end else if (serial_select_pin_a_i == `HCFG_PIN_FLOAT &&
				serial_select_pin_b_i == `HCFG_PIN_FLOAT &&
				io_mode_i != `HCFG_IOMODE_UART) begin
				serial_mode_o <= hcfg_pkg::HCFG_SER_I2C;
			end else if (io_mode_i == `HCFG_IOMODE_UART ||
				(serial_select_pin_a_i == `HCFG_PIN_FLOAT &&
				serial_select_pin_b_i == `HCFG_PIN_PD)) begin
				serial_mode_o <= hcfg_pkg::HCFG_SER_UART;
			end else begin
				serial_mode_o <= hcfg_pkg::HCFG_SER_NONE;
			end
			// smbus pin pair wins over the uart io mode
			uart_enable_o <= !(serial_select_pin_a_i == `HCFG_PIN_PU &&
				serial_select_pin_b_i == `HCFG_PIN_PU) &&
				(io_mode_i == `HCFG_IOMODE_UART ||
				(serial_select_pin_a_i == `HCFG_PIN_FLOAT &&
				serial_select_pin_b_i == `HCFG_PIN_PD));
			// modem lines in use only with the uart io mode
			uart_modem_o <= io_mode_i == `HCFG_IOMODE_UART && modem_signals_i;
		end
	end

	// attribute straps and port disable straps, sampled once
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			chg_lvl_q <= `HCFG_LVL_CHG_DEF;
			nrem_lvl_q <= `HCFG_LVL_NREM_DEF;
			port_enable_o <= '1;
		end else if (state_q == ST_SEL) begin
			chg_lvl_q <= charge_attr_strap_i;
			nrem_lvl_q <= nonrem_attr_strap_i;
			port_enable_o <= ~(port_dp_high_i & port_dm_high_i);
		end
	end

	always_comb begin
		count_d = '0;
		for (int p = 0; p < NPORTS; p++) begin
			count_d = count_d + {2'b00, port_enable_o[p]};
		end
	end

	// decoded outputs, applied in the load state and while waiting on the smbus host
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			charge_enable_o <= '0;
			nonrem_o <= '0;
			port_count_o <= 3'(NPORTS);
		end else if (state_q == ST_LOAD || state_q == ST_SMB) begin
			charge_enable_o <= chg_mask;
			nonrem_o <= nrem_mask;
			port_count_o <= count_d;
		end else if (state_q == ST_RUN) begin
			// flash path: disable straps still reduce the reported count
			port_count_o <= count_d;
		end
	end

	// power drive held low on disabled ports; enumeration after config
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			port_power_drive_o <= '0;
			enum_enable_o <= 1'b0;
			cfg_done_o <= 1'b0;
		end else begin
			port_power_drive_o <= (state_q == ST_RUN) ?
				(port_power_req_i & port_enable_o) : '0;
			enum_enable_o <= state_q == ST_RUN;
			cfg_done_o <= state_q == ST_RUN;
		end
	end
endmodule
`default_nettype wire

/* inc/hcfg_map.svh */
// constants for the hub configuration loader
`ifndef HCFG_MAP_SVH
`define HCFG_MAP_SVH
`define HCFG_NPORTS 4
`define HCFG_LVL_W 3
`define HCFG_PIN_FLOAT 2'b00
`define HCFG_PIN_PU 2'b01
`define HCFG_PIN_PD 2'b10
`define HCFG_LVL_MIN 3'h1
`define HCFG_LVL_MAX 3'h6
`define HCFG_LVL_RSVD 3'h6
`define HCFG_LVL_CHG_DEF 3'h5
`define HCFG_LVL_NREM_DEF 3'h1
`define HCFG_IOMODE_UART 3'h6
`define HCFG_PROBE_NS 1000
`define HCFG_CLK_NS 10
`define HCFG_PROBE_CYC ((`HCFG_PROBE_NS + `HCFG_CLK_NS - 1) / `HCFG_CLK_NS)
`endif

/* inc/hcfg_pkg.sv */
// types for the hub configuration loader
package hcfg_pkg;
	typedef enum logic [1:0] {
		HCFG_SRC_NONE = 2'h0,
		HCFG_SRC_FLASH = 2'h1,
		HCFG_SRC_SMBUS = 2'h2,
		HCFG_SRC_ROM = 2'h3
	} hcfg_src_t;
	typedef enum logic [1:0] {
		HCFG_SER_I2C = 2'h0,
		HCFG_SER_SMB = 2'h1,
		HCFG_SER_UART = 2'h2,
		HCFG_SER_NONE = 2'h3
	} hcfg_ser_t;
endpackage

/* core/hcfg_lvl_decode.sv */
// decodes one six-level attribute strap into a per-port mask
`timescale 1ns/10ps
`default_nettype none
`include "hcfg_map.svh"
module hcfg_lvl_decode #(
	parameter int NPORTS = `HCFG_NPORTS
) (
	input wire logic [`HCFG_LVL_W-1:0] level_i,
	input wire logic [`HCFG_LVL_W-1:0] dflt_i,
	output logic [NPORTS-1:0] mask_o
);
	logic [`HCFG_LVL_W-1:0] lvl;
	always_comb begin
		lvl = level_i;
		// out-of-range levels fall back to the default
		if (level_i < `HCFG_LVL_MIN || level_i > `HCFG_LVL_MAX) begin
			lvl = dflt_i;
		end
		mask_o = '0;
		for (int p = 0; p < NPORTS; p++) begin
			// level n covers ports 1..n-1; reserved level covers none
			if (lvl != `HCFG_LVL_RSVD && (p + 1) < int'(lvl)) begin
				mask_o[p] = 1'b1;
			end
		end
	end
endmodule
`default_nettype wire

/* sim/hcfg_loader_monitor.sv */
// port assertions for the configuration loader
`timescale 1ns/10ps
`default_nettype none
module hcfg_loader_monitor #(
	parameter int NPORTS = 4
) (
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic smbus_cfg_done_i,
	input wire logic [1:0] cfg_source_o,
	input wire logic [1:0] serial_mode_o,
	input wire logic uart_enable_o,
	input wire logic uart_modem_o,
	input wire logic rom_defaults_o,
	input wire logic flash_exec_o,
	input wire logic [NPORTS-1:0] charge_enable_o,
	input wire logic [NPORTS-1:0] nonrem_o,
	input wire logic [NPORTS-1:0] port_enable_o,
	input wire logic [2:0] port_count_o,
	input wire logic [NPORTS-1:0] port_power_drive_o,
	input wire logic enum_enable_o,
	input wire logic cfg_done_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);
	property p_pwr; (port_power_drive_o & ~port_enable_o) == '0; endproperty
	a_pwr: assert property (p_pwr) else $error("power on disabled port");
	property p_cnt; cfg_done_o |-> port_count_o == 3'($countones(port_enable_o)); endproperty
	a_cnt: assert property (p_cnt) else $error("port count wrong");
	property p_hold;
		cfg_done_o |=> $stable(charge_enable_o) && $stable(nonrem_o) && $stable(port_enable_o);
	endproperty
	a_hold: assert property (p_hold) else $error("decoded value moved");
	property p_flash; cfg_source_o == 2'h1 |-> charge_enable_o == '0 && nonrem_o == '0; endproperty
	a_flash: assert property (p_flash) else $error("straps used on flash");
	property p_wait;
		cfg_source_o == 2'h2 && !enum_enable_o && !smbus_cfg_done_i |=> !enum_enable_o;
	endproperty
	a_wait: assert property (p_wait) else $error("enumerated early");
	property p_rom; rom_defaults_o |-> cfg_source_o == 2'h3; endproperty
	a_rom: assert property (p_rom) else $error("rom without rom source");
	property p_uart; uart_enable_o |-> serial_mode_o == 2'h2; endproperty
	a_uart: assert property (p_uart) else $error("uart mode mismatch");
	property p_exec; flash_exec_o |-> cfg_source_o == 2'h1; endproperty
	a_exec: assert property (p_exec) else $error("flash exec without flash");
	c_smb: cover property (cfg_source_o == 2'h2 && enum_enable_o);
	c_flash: cover property (flash_exec_o);
	c_modem: cover property (uart_modem_o);
endmodule
bind hcfg_loader hcfg_loader_monitor #(.NPORTS(NPORTS)) u_mon (.*);
`default_nettype wire

/* sim/hcfg_smb_host.sv */
// smbus host model that releases enumeration late
`timescale 1ns/10ps
`default_nettype none
module hcfg_smb_host (
	input wire logic clk_i,
	input wire logic go_i,
	output logic done_o
);
	logic [3:0] cnt_q = 4'h0;
	always_ff @(posedge clk_i) begin
		cnt_q <= go_i ? cnt_q + 4'(cnt_q != 4'hf) : 4'h0;
	end
	assign done_o = cnt_q == 4'hf;
endmodule
`default_nettype wire

/* sim/hcfg_loader_tb.sv */
// self-checking bench for the configuration loader
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, a) begin comparisons++; if ((a) !== (e)) begin n_errors++; \
	$display("MISMATCH %s exp %0h got %0h", n, e, a); end end
module hcfg_loader_tb;
	typedef struct {logic [3:0] f; logic [1:0] pa, pb; logic [2:0] io, ch, nr;
		logic [3:0] dis; logic [1:0] src, ser;} hcfg_row_t;
	logic clk_i, sys_rst_i, flash_present_i, flash_sig_valid_i, smbus_enable_i, modem_signals_i;
	logic [1:0] serial_select_pin_a_i, serial_select_pin_b_i, cfg_source_o, serial_mode_o;
	logic [2:0] io_mode_i, charge_attr_strap_i, nonrem_attr_strap_i, port_count_o;
	logic [3:0] port_dp_high_i, port_dm_high_i, port_power_req_i, charge_enable_o, nonrem_o;
	logic [3:0] port_enable_o, port_power_drive_o, ex;
	logic smbus_cfg_done_i, uart_enable_o, uart_modem_o, rom_defaults_o, flash_exec_o;
	logic enum_enable_o, cfg_done_o, go;
	int n_errors = 0, comparisons = 0;
	hcfg_row_t r;
	// f = flash present, signature valid, smbus enabled, modem request
	hcfg_row_t rows [6] = '{
		'{4'hc, 2'h0, 2'h0, 3'h1, 3'h3, 3'h2, 4'h2, 2'h1, 2'h0},
		'{4'ha, 2'h1, 2'h1, 3'h2, 3'h1, 3'h5, 4'h8, 2'h3, 2'h1},
		'{4'h0, 2'h0, 2'h2, 3'h2, 3'h2, 3'h4, 4'h5, 2'h3, 2'h2},
		'{4'h1, 2'h0, 2'h0, 3'h6, 3'h6, 3'h6, 4'h0, 2'h3, 2'h2},
		'{4'h2, 2'h1, 2'h1, 3'h4, 3'h5, 3'h1, 4'h0, 2'h2, 2'h1},
		'{4'h0, 2'h3, 2'h3, 3'h1, 3'h4, 3'h3, 4'hf, 2'h3, 2'h3}};
	hcfg_loader #(.PROBE_CYC(2)) DUT (.*);
	hcfg_smb_host SMB (.clk_i(clk_i), .go_i(go), .done_o(smbus_cfg_done_i));
	function automatic logic [3:0] lvl(input logic [2:0] n, input logic [1:0] s);
		return (n == 3'h6 || s == 2'h1) ? 4'h0 : 4'((5'h1 << (n - 3'h1)) - 5'h1);
	endfunction
	task automatic stop_test();
		if (n_errors == 0 && comparisons > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	initial begin
		clk_i = 1'h0;
		forever #5 clk_i = ~clk_i;
	end
	initial begin
		{sys_rst_i, go, port_dp_high_i, port_power_req_i} = {2'h2, 8'hff};
		foreach (rows[i]) begin
			r = rows[i];
			@(posedge clk_i);
			{flash_present_i, flash_sig_valid_i, smbus_enable_i, modem_signals_i} <= r.f;
			{serial_select_pin_a_i, serial_select_pin_b_i, io_mode_i} <= {r.pa, r.pb, r.io};
			{charge_attr_strap_i, nonrem_attr_strap_i, port_dm_high_i} <= {r.ch, r.nr, r.dis};
			sys_rst_i <= 1'h1;
			repeat (6) @(posedge clk_i);
			`CHK("count_rst", 3'h4, port_count_o)
			sys_rst_i <= 1'h0;
			if (r.src == 2'h2) begin
				repeat (40) @(negedge clk_i);
				`CHK("enum_wait", 1'h0, enum_enable_o)
				@(posedge clk_i);
				go <= 1'h1;
			end
			for (int k = 0; cfg_done_o !== 1'h1; k++) begin
				@(negedge clk_i);
				if (k == 300) begin
					n_errors++;
					stop_test();
				end
			end
			repeat (2) @(negedge clk_i);
			ex = lvl(r.ch, r.src);
			`CHK("source", r.src, cfg_source_o)
			`CHK("serial", r.ser, serial_mode_o)
			`CHK("uart", r.ser == 2'h2, uart_enable_o)
			`CHK("modem", r.f[0], uart_modem_o)
			`CHK("rom", r.src == 2'h3, rom_defaults_o)
			`CHK("exec", r.src == 2'h1, flash_exec_o)
			`CHK("charge", ex, charge_enable_o)
			`CHK("nonrem", lvl(r.nr, r.src), nonrem_o)
			`CHK("port_en", ~r.dis, port_enable_o)
			`CHK("count", 3'h4 - 3'($countones(r.dis)), port_count_o)
			`CHK("power", ~r.dis, port_power_drive_o)
			`CHK("enum", 1'h1, enum_enable_o)
			@(posedge clk_i);
			{charge_attr_strap_i, port_dm_high_i, go} <= {3'h2, 4'hf, 1'h0};
			repeat (3) @(negedge clk_i);
			`CHK("held", ex, charge_enable_o)
		end
		@(posedge clk_i);
		sys_rst_i <= 1'h1;
		@(posedge clk_i);
		sys_rst_i <= 1'h0;
		@(negedge clk_i);
		`CHK("rst_done", 1'h0, cfg_done_o)
		`CHK("rst_en", 4'hf, port_enable_o)
		stop_test();
	end
endmodule
`default_nettype wire
